/* File: design/sel_pkg.sv */
// Package for the secondary error log: offsets, field positions, reset values and carrier types.
package sel_pkg;
  localparam logic [11:0] SEL_OFS_FIRST_ERR = 12'h138;
  localparam logic [11:0] SEL_OFS_LOG_W0    = 12'h13C;
  localparam logic [11:0] SEL_OFS_LOG_W1    = 12'h140;
  localparam logic [11:0] SEL_OFS_LOG_W2    = 12'h144;
  localparam logic [11:0] SEL_OFS_LOG_W3    = 12'h148;
  localparam logic [11:0] SEL_OFS_UNC_STAT  = 12'h12C;
  localparam int          SEL_PTR_W         = 5;
  localparam int          SEL_LCMD_LSB      = 4;
  localparam int          SEL_UCMD_LSB      = 8;
  localparam logic [31:0] SEL_RST_WORD      = 32'h0000_0000;
  localparam logic [4:0]  SEL_RST_PTR       = 5'h00;
  localparam logic [3:0]  SEL_RST_CMD       = 4'h0;

  // One captured secondary bus cycle together with the error that it raised.
  typedef struct packed {
    logic        err_valid;
    logic [4:0]  err_class;
    logic [31:0] addr_first;
    logic [31:0] addr_second;
    logic [3:0]  cmd_first;
    logic [3:0]  cmd_second;
    logic        dual_addr;
  } sel_err_evt_t;

  // Configuration read request and answer.
  typedef struct packed {
    logic        rd_en;
    logic [11:0] addr;
  } sel_cfg_req_t;

  typedef struct packed {
    logic        rd_valid;
    logic        hit;
    logic [31:0] data;
  } sel_cfg_rsp_t;
endpackage : sel_pkg

/* File: design/sel_reset_merge.sv */
// Merges the three reset sources into one asynchronous-assert, synchronous-release reset.
module sel_reset_merge (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic fundamental_reset_pin_n,
  input  wire logic global_reset_pin_n,
  output logic      log_rst_n
);
  import sel_pkg::*;

  logic       any_rst_n;
  logic [1:0] sync_ff;
  logic [1:0] nxt_sync;

  assign any_rst_n = arst_n & fundamental_reset_pin_n & global_reset_pin_n;

  always_comb begin
    nxt_sync = {sync_ff[0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge any_rst_n) begin
    if (!any_rst_n) begin
      sync_ff <= 2'b00;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign log_rst_n = sync_ff[1];
endmodule // sel_reset_merge

/* File: design/sel_error_log.sv */
// Secondary error log: first-error pointer and 128-bit header log behind config reads.

//
// Contract
// [RULE1] Read-only capability register at 138h, reset to all zeros.
// [RULE2] Bits 4:0 hold status bit position of first detected error class.
// [RULE3] Capability bits 31:5 read as zero.
// [RULE4] 128-bit log records address and command of most recent error cycle.
// [RULE5] Log words at 13Ch, 140h, 144h, 148h map bits 31:0 upward.
// [RULE6] First address phase goes to 95:64, second to 127:96.
// [RULE7] Single address cycle writes zero into log bits 127:96.
// [RULE8] First phase command lines stored in log bits 39:36.
// [RULE9] Dual address cycle stores second phase command in bits 43:40.
// [RULE10] Log bits 63:44 read as zero.
// [RULE11] Log bits 35:0 have no function and read zero.
// [RULE12] Pointer and log clear on fundamental, global or power-on reset.
// [RULE13] All log words are read-only, zero after reset.
// [RULE14] Log loads only on a detected secondary error, from that cycle.
module sel_error_log (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  fundamental_reset_pin_n,
  input  wire logic                  global_reset_pin_n,
  input  wire sel_pkg::sel_err_evt_t err_evt,
  input  wire sel_pkg::sel_cfg_req_t cfg_req,
  output sel_pkg::sel_cfg_rsp_t      cfg_rsp,
  output logic [4:0]                 first_error_pointer,
  output logic                       first_error_seen
);
  import sel_pkg::*;

  logic         log_rst_n;
  logic         first_seen_ff;
  logic         nxt_first_seen;
  logic [4:0]   first_ptr_ff;
  logic [4:0]   nxt_first_ptr;
  logic [31:0]  addr_lo_ff;
  logic [31:0]  nxt_addr_lo;
  logic [31:0]  addr_hi_ff;
  logic [31:0]  nxt_addr_hi;
  logic [3:0]   cmd_lo_ff;
  logic [3:0]   nxt_cmd_lo;
  logic [3:0]   cmd_hi_ff;
  logic [3:0]   nxt_cmd_hi;
  sel_cfg_rsp_t rsp_ff;
  sel_cfg_rsp_t nxt_rsp;
  logic [31:0]  word1;

  sel_reset_merge u_reset_merge (
    .clk_sys                 (clk_sys),
    .arst_n                  (arst_n),
    .fundamental_reset_pin_n (fundamental_reset_pin_n),
    .global_reset_pin_n      (global_reset_pin_n),
    .log_rst_n               (log_rst_n)
  );

  // Offset decode shared by the read checks below.
  function automatic logic rd_at(input sel_cfg_req_t req, input logic [11:0] ofs);
    return req.rd_en && (req.addr == ofs);
  endfunction

  function automatic logic is_mapped(input logic [11:0] ofs);
    return (ofs == SEL_OFS_FIRST_ERR) || (ofs == SEL_OFS_LOG_W0) || (ofs == SEL_OFS_LOG_W1)
      || (ofs == SEL_OFS_LOG_W2) || (ofs == SEL_OFS_LOG_W3);
  endfunction

  // Pointer latches only the first error class seen since reset.
  always_comb begin
    nxt_first_seen = first_seen_ff;
    nxt_first_ptr  = first_ptr_ff;
    if (err_evt.err_valid && !first_seen_ff) begin
      nxt_first_seen = 1'b1;
      nxt_first_ptr  = err_evt.err_class; // RULE2
    end
  end

  // The header log follows the most recent error.
  always_comb begin
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_cmd_lo  = cmd_lo_ff;
    nxt_cmd_hi  = cmd_hi_ff;
    if (err_evt.err_valid) begin // RULE14
      nxt_addr_lo = err_evt.addr_first; // RULE6
      nxt_cmd_lo  = err_evt.cmd_first; // RULE8
      if (err_evt.dual_addr) begin
        nxt_addr_hi = err_evt.addr_second; // RULE6
        nxt_cmd_hi  = err_evt.cmd_second; // RULE9
      end else begin
        nxt_addr_hi = SEL_RST_WORD; // RULE7
        nxt_cmd_hi  = SEL_RST_CMD;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge log_rst_n) begin
    if (!log_rst_n) begin // RULE12
      first_seen_ff <= 1'b0;
      first_ptr_ff  <= SEL_RST_PTR; // RULE1
    end else begin
      first_seen_ff <= nxt_first_seen;
      first_ptr_ff  <= nxt_first_ptr;
    end
  end

  always_ff @(posedge clk_sys or negedge log_rst_n) begin
    if (!log_rst_n) begin // RULE12
      addr_lo_ff <= SEL_RST_WORD; // RULE13
      addr_hi_ff <= SEL_RST_WORD;
      cmd_lo_ff  <= SEL_RST_CMD;
      cmd_hi_ff  <= SEL_RST_CMD;
    end else begin
      addr_lo_ff <= nxt_addr_lo; // RULE4
      addr_hi_ff <= nxt_addr_hi;
      cmd_lo_ff  <= nxt_cmd_lo;
      cmd_hi_ff  <= nxt_cmd_hi;
    end
  end

  assign word1 = {20'h0_0000, cmd_hi_ff, cmd_lo_ff, 4'h0}; // RULE10

  // Reads answer one cycle later; writes do not exist on this port.
  always_comb begin
    nxt_rsp          = '0;
    nxt_rsp.rd_valid = cfg_req.rd_en;
    if (cfg_req.rd_en) begin
      nxt_rsp.hit = 1'b1;
      unique case (cfg_req.addr)
        SEL_OFS_FIRST_ERR: nxt_rsp.data = {27'h000_0000, first_ptr_ff}; // RULE3
        SEL_OFS_LOG_W0:    nxt_rsp.data = SEL_RST_WORD; // RULE11
        SEL_OFS_LOG_W1:    nxt_rsp.data = word1; // RULE5
        SEL_OFS_LOG_W2:    nxt_rsp.data = addr_lo_ff;
        SEL_OFS_LOG_W3:    nxt_rsp.data = addr_hi_ff;
        default:           nxt_rsp.hit  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge log_rst_n) begin
    if (!log_rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign cfg_rsp             = rsp_ff;
  assign first_error_pointer = first_ptr_ff;
  assign first_error_seen    = first_seen_ff;

  a_first_ptr_holds: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE2
    first_seen_ff |=> (first_ptr_ff == $past(first_ptr_ff)))
    else $error("first error pointer changed after first error");

  a_ptr_captures: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE2
    (err_evt.err_valid && !first_seen_ff) |=> (first_ptr_ff == $past(err_evt.err_class)))
    else $error("first error pointer missed its class");

  a_single_addr_zero: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE7
    (err_evt.err_valid && !err_evt.dual_addr) |=> (addr_hi_ff == 32'h0000_0000))
    else $error("upper address not cleared for single address cycle");

  a_addr_first_log: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE6
    err_evt.err_valid |=> (addr_lo_ff == $past(err_evt.addr_first)))
    else $error("first address phase not logged");

  a_log_stable: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE14
    !err_evt.err_valid |=> $stable(addr_lo_ff) && $stable(cmd_lo_ff) && $stable(addr_hi_ff))
    else $error("log changed without an error");

  sequence s_read_word1;
    cfg_req.rd_en && (cfg_req.addr == SEL_OFS_LOG_W1);
  endsequence

  a_word1_reserved: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE10
    s_read_word1 |=> (cfg_rsp.data[31:12] == 20'h0_0000) && (cfg_rsp.data[3:0] == 4'h0))
    else $error("reserved log bits read nonzero");

  a_word0_zero: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE11
    (cfg_req.rd_en && cfg_req.addr == SEL_OFS_LOG_W0) |=> (cfg_rsp.data == 32'h0000_0000))
    else $error("attribute word read nonzero");

  a_cap_reserved: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE3
    (cfg_req.rd_en && cfg_req.addr == SEL_OFS_FIRST_ERR) |=> (cfg_rsp.data[31:5] == 27'h0)
      && (cfg_rsp.data[4:0] == $past(first_ptr_ff)))
    else $error("capability register read wrong");

  sequence s_err_taken;
    err_evt.err_valid;
  endsequence

  sequence s_quiet_word1_read;
    !err_evt.err_valid ##1 (rd_at(cfg_req, SEL_OFS_LOG_W1) && !err_evt.err_valid);
  endsequence

  a_cmd_lower: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE8
    s_err_taken ##1 s_quiet_word1_read |=> (cfg_rsp.data[7:4] == $past(err_evt.cmd_first, 3)))
    else $error("lower command not readable");

  a_cmd_first_log: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE8
    err_evt.err_valid |=> (cmd_lo_ff == $past(err_evt.cmd_first)))
    else $error("first phase command not logged");

  a_addr_second_log: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE6
    (err_evt.err_valid && err_evt.dual_addr) |=> (addr_hi_ff == $past(err_evt.addr_second)))
    else $error("second address phase not logged");

  a_cmd_upper_log: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE9
    (err_evt.err_valid && err_evt.dual_addr) |=> (cmd_hi_ff == $past(err_evt.cmd_second)))
    else $error("second phase command not logged");

  a_single_cmd_zero: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE9
    (err_evt.err_valid && !err_evt.dual_addr) |=> (cmd_hi_ff == 4'h0))
    else $error("upper command not cleared for single address cycle");

  a_word2_map: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE5
    rd_at(cfg_req, SEL_OFS_LOG_W2) |=> cfg_rsp.hit && (cfg_rsp.data == $past(addr_lo_ff)))
    else $error("log word two read wrong");

  a_word3_map: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE5
    rd_at(cfg_req, SEL_OFS_LOG_W3) |=> cfg_rsp.hit && (cfg_rsp.data == $past(addr_hi_ff)))
    else $error("log word three read wrong");

  a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE5
    cfg_rsp.rd_valid == $past(cfg_req.rd_en))
    else $error("read answer not one cycle after request");

  a_unmapped_miss: assert property (@(posedge clk_sys) disable iff (!log_rst_n) // RULE5
    (cfg_req.rd_en && !is_mapped(cfg_req.addr)) |=> !cfg_rsp.hit && (cfg_rsp.data == 32'h0000_0000))
    else $error("unmapped offset answered as a hit");

  a_reset_clears: assert property (@(posedge clk_sys) // RULE12
    !log_rst_n |-> (first_ptr_ff == 5'h00) && !first_seen_ff && (addr_lo_ff == 32'h0000_0000)
      && (addr_hi_ff == 32'h0000_0000) && (cmd_lo_ff == 4'h0) && (cmd_hi_ff == 4'h0))
    else $error("log not cleared while reset is held");
endmodule // sel_error_log

/* File: bench/sel_pci_agent.sv */
// Partner model: secondary bus agents that report one errored bus cycle at a time.
module sel_pci_agent (
  input  wire logic             clk_sys,
  output sel_pkg::sel_err_evt_t err_evt
);
  timeunit 1ns;
  timeprecision 1ns;
  import sel_pkg::*;

  initial begin
    err_evt = '0;
  end

  // One-cycle error report; afterwards the lines show inverted stale values, never a clean copy.
  task automatic send(input logic [4:0] cls, input logic [31:0] a1, input logic [31:0] a2,
                      input logic [3:0] c1, input logic [3:0] c2, input logic dual);
    sel_err_evt_t ev;
    @(negedge clk_sys);
    err_evt = '{err_valid: 1'b1, err_class: cls, addr_first: a1, addr_second: a2,
                cmd_first: c1, cmd_second: c2, dual_addr: dual};
    @(negedge clk_sys);
    ev = ~err_evt;
    ev.err_valid = 1'b0;
    err_evt = ev;
  endtask
endmodule // sel_pci_agent

/* File: bench/secondary_error_log_tb_top.sv */
// Self-checking bench for the secondary error log.
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module secondary_error_log_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sel_pkg::*;

  logic         clk_sys = 1'b0;
  logic         arst_n = 1'b0;
  logic         fundamental_reset_pin_n = 1'b1;
  logic         global_reset_pin_n = 1'b1;
  sel_err_evt_t err_evt;
  sel_cfg_req_t cfg_req = '0;
  sel_cfg_rsp_t cfg_rsp;
  logic [4:0]   first_error_pointer;
  logic         first_error_seen;
  int           error_cnt = 0;
  int           cmp_count = 0;

  sel_pci_agent i_sel_pci_agent (.clk_sys(clk_sys), .err_evt(err_evt));
  sel_error_log i_sel_error_log (.clk_sys(clk_sys), .arst_n(arst_n),
    .fundamental_reset_pin_n(fundamental_reset_pin_n), .global_reset_pin_n(global_reset_pin_n),
    .err_evt(err_evt), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .first_error_pointer(first_error_pointer), .first_error_seen(first_error_seen));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Single read; the answer stands for one cycle and is sampled mid-cycle.
  task automatic rd(input logic [11:0] a, input logic exp_hit, output logic [31:0] d);
    @(negedge clk_sys) cfg_req = '{rd_en: 1'b1, addr: a};
    @(negedge clk_sys) cfg_req.rd_en = 1'b0;
    `CHK("rd_valid", 1'b1, cfg_rsp.rd_valid)
    `CHK("hit", exp_hit, cfg_rsp.hit)
    d = cfg_rsp.data;
  endtask

  task automatic chk_log(input logic [4:0] p, input logic seen, input logic [31:0] a1,
                         input logic [31:0] a2, input logic [3:0] c1, input logic [3:0] c2,
                         input logic dual);
    logic [31:0] d;
    `CHK("pointer_port", p, first_error_pointer)
    `CHK("seen_port", seen, first_error_seen)
    rd(SEL_OFS_FIRST_ERR, 1'b1, d);
    `CHK("pointer_reg", {27'h0000000, p}, d)
    rd(SEL_OFS_LOG_W0, 1'b1, d);
    `CHK("log_word0", 32'h0000_0000, d)
    rd(SEL_OFS_LOG_W1, 1'b1, d);
    `CHK("log_word1", {20'h00000, (dual ? c2 : 4'h0), c1, 4'h0}, d)
    rd(SEL_OFS_LOG_W2, 1'b1, d);
    `CHK("log_word2", a1, d)
    rd(SEL_OFS_LOG_W3, 1'b1, d);
    `CHK("log_word3", (dual ? a2 : 32'h0000_0000), d)
  endtask

  task automatic t_reset_values();
    logic [31:0] d;
    chk_log(5'h00, 1'b0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b0);
    rd(SEL_OFS_UNC_STAT, 1'b0, d);
    `CHK("unmapped_low", 32'h0000_0000, d)
    rd(12'h14C, 1'b0, d);
    `CHK("unmapped_high", 32'h0000_0000, d)
  endtask

  // Single-address cycle: upper address and upper command must come back zero.
  task automatic t_single_addr();
    i_sel_pci_agent.send(5'h0C, 32'h1234_5678, 32'hDEAD_BEEF, 4'h6, 4'hD, 1'b0);
    chk_log(5'h0C, 1'b1, 32'h1234_5678, 32'h0, 4'h6, 4'hD, 1'b0);
  endtask

  // A later dual-address error replaces the log but leaves the pointer on the first class.
  task automatic t_dual_latest();
    logic [31:0] d;
    i_sel_pci_agent.send(5'h09, 32'hA5A5_0F0F, 32'h0000_00C3, 4'hD, 4'h7, 1'b1);
    rd(SEL_OFS_LOG_W1, 1'b1, d);
    `CHK("word1_early", {20'h00000, 4'h7, 4'hD, 4'h0}, d)
    chk_log(5'h0C, 1'b1, 32'hA5A5_0F0F, 32'h0000_00C3, 4'hD, 4'h7, 1'b1);
  endtask

  task automatic t_pin_reset(input logic use_global);
    @(negedge clk_sys);
    if (use_global) global_reset_pin_n = 1'b0;
    else fundamental_reset_pin_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK("pointer_in_reset", 5'h00, first_error_pointer)
    fundamental_reset_pin_n = 1'b1;
    global_reset_pin_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_log(5'h00, 1'b0, 32'h0, 32'h0, 4'h0, 4'h0, 1'b0);
    i_sel_pci_agent.send(5'h1F, 32'hFFFF_0001, 32'h8000_0000, 4'hF, 4'hE, 1'b1);
    chk_log(5'h1F, 1'b1, 32'hFFFF_0001, 32'h8000_0000, 4'hF, 4'hE, 1'b1);
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset_values();
    t_single_addr();
    t_dual_latest();
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    conclude();
  end

  // The sequence needs well under 400 cycles; 2000 marks a hang.
  initial begin
    #(100 * 2000);
    error_cnt++;
    conclude();
  end
endmodule // secondary_error_log_tb_top
